// *** rtl/ext_bus_params.svh ***
// Constants of the external bus wait and sharing block
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define GLOBAL_SIZE_ADDR 16'h0005
`define GLOBAL_SIZE_RESET 8'h00
`define GLOBAL_REGION_TOP 16'hffff
`endif

// *** rtl/ext_bus_pkg.sv ***
// Types of the external bus wait and sharing block
package ext_bus_pkg;
  typedef enum logic [1:0] {
    SPACE_PROG = 2'b00,
    SPACE_DATA = 2'b01,
    SPACE_IO = 2'b10
  } space_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic write;
    space_t space;
  } core_req_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic write_n;
    logic prog_n;
    logic data_n;
    logic io_n;
    logic strobe_n;
  } pins_t;
endpackage

// *** rtl/ext_bus_wait_share.sv ***
// External bus interface with ready waits, global region request and hold
`timescale 1ns/1ns
`include "ext_bus_params.svh"
module ext_bus_wait_share (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // Core side request
  input wire logic i_req_valid,
  input wire ext_bus_pkg::core_req_t i_req,
  input wire logic i_req_internal,
  input wire logic i_instr_last,
  input wire logic i_irq,
  // External pins
  input wire logic i_ready,
  input wire logic i_hold_req_n,
  input wire logic [15:0] i_data_in,
  output logic [15:0] o_addr,
  output logic o_addr_oe,
  output logic [15:0] o_data,
  output logic o_data_oe,
  output logic o_write_n,
  output logic o_prog_n,
  output logic o_data_sel_n,
  output logic o_io_n,
  output logic o_strobe_n,
  output logic o_ctrl_oe,
  output logic o_shared_bus_request_n,
  output logic o_bus_release_ack_n,
  // Core side answer
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_stall,
  output logic o_irq_take,
  output logic [7:0] o_global_region_size
);
  import ext_bus_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_HOLD = 2'b10
  } state_t;

  state_t state;
  state_t next_state;
  logic [7:0] global_region_size;
  logic busy;

  // Operand inside the global data region
  function automatic logic in_global(input core_req_t r, input logic [7:0] size);
    logic [15:0] base;
    base = `GLOBAL_REGION_TOP - {size, 8'h00} + 16'h0001;
    in_global = (r.space == SPACE_DATA) && (r.addr >= base) && (size != 8'h00);
  endfunction

  wire logic reg_hit = i_req_valid && i_req_internal && i_req.write &&
    (i_req.space == SPACE_DATA) && (i_req.addr == `GLOBAL_SIZE_ADDR);
  wire logic ext_start = i_req_valid && !i_req_internal && (state == ST_IDLE) &&
    i_hold_req_n;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      global_region_size <= `GLOBAL_SIZE_RESET;
    end else if (reg_hit) begin
      global_region_size <= i_req.wdata[7:0];
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!i_hold_req_n) begin
          next_state = ST_HOLD;
        end else if (ext_start) begin
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (i_ready) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (i_hold_req_n) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_addr <= 16'h0000;
      o_data <= 16'h0000;
      o_write_n <= 1'b1;
      o_prog_n <= 1'b1;
      o_data_sel_n <= 1'b1;
      o_io_n <= 1'b1;
      o_strobe_n <= 1'b1;
      o_data_oe <= 1'b0;
    end else if (ext_start) begin
      o_addr <= i_req.addr;
      o_data <= i_req.wdata;
      o_write_n <= !i_req.write;
      o_prog_n <= (i_req.space != SPACE_PROG);
      o_data_sel_n <= (i_req.space != SPACE_DATA);
      o_io_n <= (i_req.space != SPACE_IO);
      o_strobe_n <= 1'b0;
      o_data_oe <= i_req.write;
    end else if (state == ST_ACCESS && i_ready) begin
      o_strobe_n <= 1'b1;
      o_prog_n <= 1'b1;
      o_data_sel_n <= 1'b1;
      o_io_n <= 1'b1;
      o_write_n <= 1'b1;
      o_data_oe <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_addr_oe <= 1'b1;
      o_ctrl_oe <= 1'b1;
      o_bus_release_ack_n <= 1'b1;
    end else begin
      o_addr_oe <= (next_state != ST_HOLD);
      o_ctrl_oe <= (next_state != ST_HOLD);
      o_bus_release_ack_n <= (next_state != ST_HOLD);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_shared_bus_request_n <= 1'b1;
    end else if (ext_start) begin
      o_shared_bus_request_n <= !in_global(i_req, global_region_size);
    end else if (state == ST_ACCESS && i_ready) begin
      o_shared_bus_request_n <= 1'b1;
    end
  end

  assign busy = (state == ST_ACCESS) && !i_ready;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_stall <= 1'b0;
    end else begin
      o_done <= (state == ST_ACCESS && i_ready) || (i_req_valid && i_req_internal);
      if (state == ST_ACCESS && i_ready) begin
        o_rdata <= i_data_in;
      end
      o_stall <= (next_state == ST_ACCESS) ||
        (i_req_valid && !i_req_internal && next_state != ST_ACCESS);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_irq_take <= 1'b0;
    end else begin
      o_irq_take <= i_irq && i_instr_last && !busy && !ext_start;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_global_region_size <= `GLOBAL_SIZE_RESET;
    end else begin
      o_global_region_size <= global_region_size;
    end
  end

  property p_hold_ack;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state == ST_IDLE && !i_hold_req_n) |=> (!o_bus_release_ack_n && !o_addr_oe);
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("hold not acknowledged");

  property p_wait;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state == ST_ACCESS && !i_ready) |=> (state == ST_ACCESS && !o_strobe_n);
  endproperty
  a_wait: assert property (p_wait) else $error("access ended without ready");

  property p_done;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state == ST_ACCESS && i_ready) |=> (o_done && o_strobe_n);
  endproperty
  a_done: assert property (p_done) else $error("ready did not finish access");

  property p_greq;
    @(posedge i_ref_clk) disable iff (i_srst)
      ext_start && (i_req.space == SPACE_DATA) && (global_region_size != 8'h00) &&
        (i_req.addr[15:8] >= 8'h00 - global_region_size) |=> !o_shared_bus_request_n;
  endproperty
  a_greq: assert property (p_greq) else $error("global request missing");

  property p_nogreq;
    @(posedge i_ref_clk) disable iff (i_srst)
      ext_start && !((i_req.space == SPACE_DATA) && (global_region_size != 8'h00) &&
        (i_req.addr[15:8] >= 8'h00 - global_region_size)) |=> o_shared_bus_request_n;
  endproperty
  a_nogreq: assert property (p_nogreq) else $error("spurious global request");

  property p_global_wait;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state == ST_ACCESS && !i_ready && !o_shared_bus_request_n) |=>
        (!o_shared_bus_request_n && !o_strobe_n);
  endproperty
  a_global_wait: assert property (p_global_wait) else $error("global cycle cut short");

  property p_reg;
    @(posedge i_ref_clk) disable iff (i_srst)
      reg_hit |=> ##1 (o_global_region_size == $past(i_req.wdata[7:0], 2));
  endproperty
  a_reg: assert property (p_reg) else $error("size register not written");

  property p_irq;
    @(posedge i_ref_clk) disable iff (i_srst)
      busy |=> !o_irq_take;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt taken in wait");

  property p_space;
    @(posedge i_ref_clk) disable iff (i_srst)
      ext_start && i_req.space == SPACE_IO |=> (!o_io_n && o_addr == $past(i_req.addr));
  endproperty
  a_space: assert property (p_space) else $error("io access not like memory");

  property p_internal;
    @(posedge i_ref_clk) disable iff (i_srst)
      (state == ST_HOLD && i_req_valid && i_req_internal) |=> o_done;
  endproperty
  a_internal: assert property (p_internal) else $error("internal stalled in hold");

  c_wait: cover property (@(posedge i_ref_clk) state == ST_ACCESS && !i_ready ##1 i_ready);
  c_hold: cover property (@(posedge i_ref_clk) state == ST_HOLD);
  c_greq: cover property (@(posedge i_ref_clk) !o_shared_bus_request_n);
endmodule // ext_bus_wait_share

// *** bench/ext_mem_model.sv ***
// Partner model: slow external memory and a hold master
`timescale 1ns/1ns
module ext_mem_model (
  // Clock and pins
  input wire logic i_clk,
  input wire logic i_strobe_n,
  input wire logic [15:0] i_addr,
  // Bench commands
  input wire logic [3:0] i_waits,
  input wire logic i_hold_cmd,
  // Answers
  output logic o_ready,
  output logic o_hold_req_n,
  output logic [15:0] o_rdata
);
  logic [3:0] cnt = 4'h0;
  initial begin
    o_ready = 1'b0;
    o_rdata = 16'h0000;
  end
  always @(negedge i_clk) begin
    cnt <= i_strobe_n ? 4'h0 : cnt + 4'h1;
    o_ready <= !i_strobe_n && cnt >= i_waits;
    o_rdata <= i_strobe_n ? ~o_rdata : i_addr ^ 16'h5a5a;
  end
  assign o_hold_req_n = !i_hold_cmd;
endmodule // ext_mem_model

// *** bench/testbench.sv ***
// Testbench for the external bus wait and sharing block
`timescale 1ns/1ns
`include "ext_bus_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench;
  import ext_bus_pkg::*;
  logic clk = 1'b0, srst = 1'b1, valid = 1'b0, intl = 1'b0, last = 1'b0, irq = 1'b0;
  logic hold_cmd = 1'b0, ready, hold_n, a_oe, d_oe, c_oe, wr_n, p_n, ds_n, io_n, st_n;
  logic br_n, ack_n, done, stall, take;
  logic [3:0] waits = 4'h0;
  logic [15:0] din, addr, dout, rdata;
  logic [7:0] size;
  core_req_t req = '0;
  int miscompares = 0, tests_run = 0, n;
  always #50 clk = ~clk;
  ext_bus_wait_share dut (.i_ref_clk(clk), .i_srst(srst), .i_req_valid(valid), .i_req(req),
    .i_req_internal(intl), .i_instr_last(last), .i_irq(irq), .i_ready(ready),
    .i_hold_req_n(hold_n), .i_data_in(din), .o_addr(addr), .o_addr_oe(a_oe), .o_data(dout),
    .o_data_oe(d_oe), .o_write_n(wr_n), .o_prog_n(p_n), .o_data_sel_n(ds_n), .o_io_n(io_n),
    .o_strobe_n(st_n), .o_ctrl_oe(c_oe), .o_shared_bus_request_n(br_n),
    .o_bus_release_ack_n(ack_n), .o_done(done), .o_rdata(rdata), .o_stall(stall),
    .o_irq_take(take), .o_global_region_size(size));
  ext_mem_model far (.i_clk(clk), .i_strobe_n(st_n), .i_addr(addr), .i_waits(waits),
    .i_hold_cmd(hold_cmd), .o_ready(ready), .o_hold_req_n(hold_n), .o_rdata(din));
  task automatic summarize();
    $display("counts: %0d checks, %0d wrong", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One external access, pins and length checked
  task automatic access(input space_t sp, input logic [15:0] a, input logic wr, input logic br);
    @(negedge clk);
    req = '{a, a ^ 16'h0f0f, wr, sp};
    valid = 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
      if (n == 1) begin
        `CHK("strobe", 1'b0, st_n)
        `CHK("addr", a, addr)
        `CHK("select", {sp != SPACE_PROG, sp != SPACE_DATA, sp != SPACE_IO}, {p_n, ds_n, io_n})
        `CHK("bus request", !br, br_n)
        `CHK("write", {!wr, wr}, {wr_n, d_oe})
        if (wr) `CHK("wdata", a ^ 16'h0f0f, dout)
      end
      if (done !== 1'b1) `CHK("irq held", 1'b0, take)
      if (done !== 1'b1) `CHK("stall", 1'b1, stall)
    end
    valid = 1'b0;
    `CHK("cycles", 2 + waits, n)
    if (!wr) `CHK("rdata", a ^ 16'h5a5a, rdata)
  endtask
  // Internal write of the region size
  task automatic set_size(input logic [7:0] s);
    @(negedge clk);
    req = '{`GLOBAL_SIZE_ADDR, {8'h00, s}, 1'b1, SPACE_DATA};
    intl = 1'b1;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    intl = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("region size", s, size)
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    `CHK("size reset", `GLOBAL_SIZE_RESET, size)
    access(SPACE_PROG, 16'h1234, 1'b0, 1'b0);
    access(SPACE_IO, 16'h0007, 1'b1, 1'b0);
    waits = 4'h3;
    access(SPACE_DATA, 16'h8001, 1'b0, 1'b0);
    $display("test spaces and waits done");
    set_size(8'h02);
    irq = 1'b1;
    last = 1'b1;
    access(SPACE_DATA, 16'hfe00, 1'b1, 1'b1);
    waits = 4'h0;
    access(SPACE_DATA, 16'hfdff, 1'b0, 1'b0);
    access(SPACE_PROG, 16'hff00, 1'b0, 1'b0);
    last = 1'b1;
    n = 0;
    while (take !== 1'b1 && n < 5) begin
      @(negedge clk);
      n++;
    end
    `CHK("irq taken", 1'b1, take)
    irq = 1'b0;
    last = 1'b0;
    $display("test global region done");
    hold_cmd = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("hold pins", 4'h0, {a_oe, d_oe, c_oe, ack_n})
    req = '{16'h0100, 16'h0000, 1'b0, SPACE_DATA};
    intl = 1'b1;
    valid = 1'b1;
    @(negedge clk);
    `CHK("internal in hold", 1'b0, stall)
    intl = 1'b0;
    @(negedge clk);
    `CHK("refused in hold", 2'b11, {stall, st_n})
    valid = 1'b0;
    hold_cmd = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("hold released", 3'b111, {a_oe, c_oe, ack_n})
    access(SPACE_IO, 16'h000f, 1'b0, 1'b0);
    $display("test hold done");
    summarize();
  end
  initial begin
    #(2000 * 100);
    miscompares++;
    summarize();
  end
endmodule // testbench
